// File: rtl/pmic_pkg.sv
package pmic_pkg;
   // register map, one byte per address
   localparam int          NUM_REGS     = 18;
   localparam logic [7:0]  ADDR_RSVD0   = 8'h00;
   localparam logic [7:0]  ADDR_CHEN    = 8'h01;
   localparam logic [7:0]  ADDR_CH1     = 8'h02;
   localparam logic [7:0]  ADDR_CH23    = 8'h03;
   localparam logic [7:0]  ADDR_CH4     = 8'h04;
   localparam logic [7:0]  ADDR_RAMP    = 8'h05;
   localparam logic [7:0]  ADDR_MODE    = 8'h06;
   localparam logic [7:0]  ADDR_LATCH   = 8'h07;
   localparam logic [7:0]  ADDR_SWCFG   = 8'h08;
   localparam logic [7:0]  ADDR_THRESH  = 8'h09;
   localparam logic [7:0]  ADDR_RETRY   = 8'h0a;
   localparam logic [7:0]  ADDR_PGSEL   = 8'h0b;
   localparam logic [7:0]  ADDR_LFAULT  = 8'h0c;
   localparam logic [7:0]  ADDR_PGSTATE = 8'h0d;
   localparam logic [7:0]  ADDR_EVFLAG  = 8'h0e;
   localparam logic [7:0]  ADDR_EVMASK  = 8'h0f;
   localparam logic [7:0]  ADDR_RSVD16  = 8'h10;
   localparam logic [7:0]  ADDR_LAST    = 8'h11;

   // field layout and reset values
   localparam int          NUM_CHAN     = 5;
   localparam int          NUM_PG       = 4;
   localparam int          CODE_W       = 5;
   localparam logic [7:0]  CHEN_RST     = 8'h1f;
   localparam logic [7:0]  REG_RST      = 8'h00;

   // channel 1 output voltage, millivolts
   localparam logic [10:0] VOUT_ADJ_MV   = 11'h320;
   localparam logic [10:0] VOUT_FIRST_MV = 11'h352;
   localparam logic [10:0] VOUT_STEP_MV  = 11'h019;

   // fuse strap settles through the synchroniser before it is taken
   localparam logic [1:0]  FUSE_WAIT    = 2'h3;
   localparam logic [3:0]  BIT_LAST     = 4'h8;

   typedef enum logic [3:0] {
      PMIC_IDLE  = 4'h0,
      PMIC_ADDR  = 4'h1,
      PMIC_AACK  = 4'h3,
      PMIC_PTR   = 4'h2,
      PMIC_PACK  = 4'h6,
      PMIC_WDATA = 4'h7,
      PMIC_WACK  = 4'h5,
      PMIC_RDATA = 4'h4,
      PMIC_MACK  = 4'hc
   } pmic_i2c_e;
endpackage

// File: rtl/pmic_sync.sv
module pmic_sync
   import pmic_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] ff1;
      logic [W-1:0] ff2;
   } pmic_sync_s;

   pmic_sync_s s_r;
   pmic_sync_s s_nxt;

   // first stage feeds only the second stage
   always_comb begin
      s_nxt     = s_r;
      s_nxt.ff1 = din;
      s_nxt.ff2 = s_r.ff1;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign dout = s_r.ff2;
endmodule

// File: rtl/pmic_control_register_bank.sv
module pmic_control_register_bank
   import pmic_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h34  // arbitrary bus address
) (
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                scl_i,
   input  wire logic                sda_i,
   output logic                     sda_o,
   output logic                     sda_oe,
   input  wire logic [NUM_CHAN-1:0] chan_enable_pin,
   input  wire logic [NUM_PG-1:0]   power_good_in,
   input  wire logic [CODE_W-1:0]   fuse_ch1_code,
   output logic      [NUM_CHAN-1:0] chan_run,
   output logic      [CODE_W-1:0]   ch1_voltage_field,
   output logic      [10:0]         ch1_vout_mv,
   output logic      [7:0]          ch23_code_out,
   output logic      [7:0]          ch4_code_out,
   output logic      [7:0]          ramp_cfg_out,
   output logic      [7:0]          mode_cfg_out,
   output logic      [7:0]          latchoff_cfg_out,
   output logic      [7:0]          switching_cfg_out,
   output logic      [7:0]          threshold_cfg_out,
   output logic      [7:0]          retry_cfg_out,
   output logic      [7:0]          pg_select_out,
   output logic      [7:0]          event_mask_out,
   output logic      [7:0]          restore_cfg_out
);
   localparam int SYNC_W = 2 + NUM_CHAN + NUM_PG + CODE_W;

   typedef struct packed {
      logic [NUM_REGS-1:0][7:0] regs;
      pmic_i2c_e                st;
      logic [3:0]               bitcnt;
      logic [7:0]               shreg;
      logic [7:0]               ptr;
      logic                     rd;
      logic                     scl_q;
      logic                     sda_q;
      logic                     sda_oe;
      logic                     sda_o;
      logic [1:0]               fuse_cnt;
      logic                     fuse_done;
      logic [NUM_CHAN-1:0]      chan_run;
      logic [10:0]              ch1_mv;
   } pmic_state_s;

   pmic_state_s         s_r;
   pmic_state_s         s_nxt;
   logic [SYNC_W-1:0]   sync_in;
   logic [SYNC_W-1:0]   sync_out;
   logic                scl_s;
   logic                sda_s;
   logic [NUM_CHAN-1:0] pin_s;
   logic [NUM_PG-1:0]   pg_s;
   logic [CODE_W-1:0]   fuse_s;
   logic                scl_rise;
   logic                scl_fall;
   logic                bus_start;
   logic                bus_stop;
   logic                wr_fire;
   logic [7:0]          wr_data;
   logic [7:0]          rd_byte;
   logic [CODE_W-1:0]   ch1_code;

   // every pin crosses two flops before the logic looks at it
   assign sync_in = {scl_i, sda_i, chan_enable_pin, power_good_in, fuse_ch1_code};

   pmic_sync #(
      .W (SYNC_W)
   ) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .din  (sync_in),
      .dout (sync_out)
   );

   assign {scl_s, sda_s, pin_s, pg_s, fuse_s} = sync_out;

   // bus events from the synchronised lines against last cycle
   assign scl_rise  = scl_s & ~s_r.scl_q;
   assign scl_fall  = ~scl_s & s_r.scl_q;
   assign bus_start = scl_s & s_r.scl_q & s_r.sda_q & ~sda_s;
   assign bus_stop  = scl_s & s_r.scl_q & ~s_r.sda_q & sda_s;

   assign ch1_code = s_r.regs[ADDR_CH1][CODE_W-1:0];

   // read mux; reserved and unmapped addresses answer zero
   // reserved read zero
   always_comb begin
      rd_byte = REG_RST;
      if (s_r.ptr == ADDR_PGSTATE) begin
         rd_byte = {{(8-NUM_PG){1'b0}}, pg_s};
      end else if (s_r.ptr <= ADDR_LAST && s_r.ptr != ADDR_RSVD0 && s_r.ptr != ADDR_RSVD16) begin
         rd_byte = s_r.regs[s_r.ptr[4:0]];
      end
   end

   // next state: fuse load, serial slave, register update, outputs
   always_comb begin
      s_nxt       = s_r;
      wr_fire     = 1'b0;
      wr_data     = s_r.shreg;
      s_nxt.scl_q = scl_s;
      s_nxt.sda_q = sda_s;

      if (!s_r.fuse_done) begin
         if (s_r.fuse_cnt == FUSE_WAIT) begin
            s_nxt.regs[ADDR_CH1][CODE_W-1:0] = fuse_s;
            s_nxt.fuse_done                  = 1'b1;
         end else begin
            s_nxt.fuse_cnt = 2'(s_r.fuse_cnt + 2'h1);
         end
      end

      // start and stop win over any bit in progress
      if (bus_start) begin
         s_nxt.st     = PMIC_ADDR;
         s_nxt.bitcnt = '0;
         s_nxt.sda_oe = 1'b0;
      end else if (bus_stop) begin
         s_nxt.st     = PMIC_IDLE;
         s_nxt.sda_oe = 1'b0;
      end else begin
         unique case (s_r.st)
            PMIC_IDLE: begin
               s_nxt.sda_oe = 1'b0;
            end
            PMIC_ADDR, PMIC_PTR, PMIC_WDATA: begin
               if (scl_rise) begin
                  s_nxt.shreg  = {s_r.shreg[6:0], sda_s};
                  s_nxt.bitcnt = 4'(s_r.bitcnt + 4'h1);
               end else if (scl_fall && s_r.bitcnt == BIT_LAST) begin
                  s_nxt.bitcnt = '0;
                  if (s_r.st == PMIC_ADDR) begin
                     // foreign address: stay off the bus until next start
                     if (s_r.shreg[7:1] == DEV_ADDR) begin
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.rd     = s_r.shreg[0];
                        s_nxt.st     = PMIC_AACK;
                     end else begin
                        s_nxt.st = PMIC_IDLE;
                     end
                  end else if (s_r.st == PMIC_PTR) begin
                     s_nxt.ptr    = s_r.shreg;
                     s_nxt.sda_oe = 1'b1;
                     s_nxt.st     = PMIC_PACK;
                  end else begin
                     wr_fire      = 1'b1;
                     s_nxt.sda_oe = 1'b1;
                     s_nxt.st     = PMIC_WACK;
                  end
               end
            end
            PMIC_AACK: begin
               if (scl_fall) begin
                  if (s_r.rd) begin
                     s_nxt.shreg  = rd_byte;
                     s_nxt.sda_oe = ~rd_byte[7];
                     s_nxt.st     = PMIC_RDATA;
                  end else begin
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.st     = PMIC_PTR;
                  end
               end
            end
            PMIC_PACK: begin
               if (scl_fall) begin
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.st     = PMIC_WDATA;
               end
            end
            PMIC_WACK: begin
               // auto increment lets a burst fill consecutive registers
               if (scl_fall) begin
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.ptr    = 8'(s_r.ptr + 8'h01);
                  s_nxt.st     = PMIC_WDATA;
               end
            end
            PMIC_RDATA: begin
               if (scl_rise) begin
                  s_nxt.bitcnt = 4'(s_r.bitcnt + 4'h1);
               end else if (scl_fall) begin
                  if (s_r.bitcnt == BIT_LAST) begin
                     s_nxt.bitcnt = '0;
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.ptr    = 8'(s_r.ptr + 8'h01);
                     s_nxt.st     = PMIC_MACK;
                  end else begin
                     s_nxt.shreg  = {s_r.shreg[6:0], 1'b0};
                     s_nxt.sda_oe = ~s_r.shreg[6];
                  end
               end
            end
            PMIC_MACK: begin
               // a high ninth bit from the master ends the read burst
               if (scl_rise && sda_s) begin
                  s_nxt.st = PMIC_IDLE;
               end else if (scl_fall) begin
                  s_nxt.shreg  = rd_byte;
                  s_nxt.sda_oe = ~rd_byte[7];
                  s_nxt.st     = PMIC_RDATA;
               end
            end
            default: begin
               s_nxt.st     = PMIC_IDLE;
               s_nxt.sda_oe = 1'b0;
            end
         endcase
      end

      // register writes; reserved, read-only and unmapped bytes ignored
      // map decode
      if (wr_fire && s_r.ptr <= ADDR_LAST && s_r.ptr != ADDR_RSVD0
          && s_r.ptr != ADDR_RSVD16 && s_r.ptr != ADDR_PGSTATE) begin
         if (s_r.ptr == ADDR_CHEN) begin
            s_nxt.regs[ADDR_CHEN] = {wr_data[7:NUM_CHAN],
                                     (wr_data[NUM_CHAN-1:0] & pin_s) |
                                     (s_r.regs[ADDR_CHEN][NUM_CHAN-1:0] & ~pin_s)};
         end else if (s_r.ptr == ADDR_CH1) begin
            s_nxt.regs[ADDR_CH1] = wr_data;
         end else begin
            s_nxt.regs[s_r.ptr[4:0]] = wr_data;
         end
      end

      s_nxt.regs[ADDR_CHEN][NUM_CHAN-1:0] = s_nxt.regs[ADDR_CHEN][NUM_CHAN-1:0] | ~pin_s;

      s_nxt.chan_run = s_r.regs[ADDR_CHEN][NUM_CHAN-1:0] & pin_s;

      if (ch1_code == '0) begin
         s_nxt.ch1_mv = VOUT_ADJ_MV;
      end else begin
         s_nxt.ch1_mv = 11'(VOUT_FIRST_MV + VOUT_STEP_MV * {6'h00, 5'(ch1_code - 5'h01)});
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_r                 <= '0;
         s_r.regs[ADDR_CHEN] <= CHEN_RST;
         s_r.st              <= PMIC_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // open drain: the line is only ever pulled low
   assign sda_o             = s_r.sda_o;
   assign sda_oe            = s_r.sda_oe;
   assign chan_run          = s_r.chan_run;
   assign ch1_voltage_field = s_r.regs[ADDR_CH1][CODE_W-1:0];
   assign ch1_vout_mv       = s_r.ch1_mv;
   assign ch23_code_out     = s_r.regs[ADDR_CH23];
   assign ch4_code_out      = s_r.regs[ADDR_CH4];
   assign ramp_cfg_out      = s_r.regs[ADDR_RAMP];
   assign mode_cfg_out      = s_r.regs[ADDR_MODE];
   assign latchoff_cfg_out  = s_r.regs[ADDR_LATCH];
   assign switching_cfg_out = s_r.regs[ADDR_SWCFG];
   assign threshold_cfg_out = s_r.regs[ADDR_THRESH];
   assign retry_cfg_out     = s_r.regs[ADDR_RETRY];
   assign pg_select_out     = s_r.regs[ADDR_PGSEL];
   assign event_mask_out    = s_r.regs[ADDR_EVMASK];
   assign restore_cfg_out   = s_r.regs[ADDR_LAST];

   // checks on the register bank and channel outputs
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   run_and_gate_a: assert property ($past(rstn) |->
      chan_run == ($past(s_r.regs[ADDR_CHEN][NUM_CHAN-1:0]) & $past(pin_s)))
      else $error("channel run is not enable and pin");

   pin_low_restore_a: assert property (
      (~$past(pin_s) & ~s_r.regs[ADDR_CHEN][NUM_CHAN-1:0]) == '0)
      else $error("software enable not restored while pin low");

   clear_needs_pin_a: assert property (
      ($past(s_r.regs[ADDR_CHEN][NUM_CHAN-1:0]) & ~s_r.regs[ADDR_CHEN][NUM_CHAN-1:0]
       & ~$past(pin_s)) == '0)
      else $error("enable bit cleared while its pin was low");

   reset_default_a: assert property (!$past(rstn) |-> s_r.regs[ADDR_CHEN] == CHEN_RST)
      else $error("channel enable register wrong after reset");

   // reserved bits keep what the host wrote
   upper_bits_rw_a: assert property (
      ($past(wr_fire) && $past(s_r.ptr) == ADDR_CHEN) |->
      s_r.regs[ADDR_CHEN][7:NUM_CHAN] == $past(wr_data[7:NUM_CHAN]))
      else $error("reserved enable bits did not take the write");

   fuse_load_a: assert property ((!$past(s_r.fuse_done) && s_r.fuse_done) |->
      s_r.regs[ADDR_CH1][CODE_W-1:0] == $past(fuse_s))
      else $error("voltage code not taken from fuse");

   vout_adjust_a: assert property (($past(rstn) && $past(ch1_code) == '0) |->
      ch1_vout_mv == VOUT_ADJ_MV)
      else $error("code zero does not give adjustable setting");

   vout_step_a: assert property (($past(rstn) && $past(ch1_code) != '0) |->
      ch1_vout_mv == 11'(VOUT_ADJ_MV + VOUT_STEP_MV * {6'h00, $past(ch1_code)} + VOUT_STEP_MV))
      else $error("voltage step is not 25 mV per code");

   reserved_zero_a: assert property (
      s_r.regs[ADDR_RSVD0] == REG_RST && s_r.regs[ADDR_RSVD16] == REG_RST)
      else $error("reserved register changed");

   chen_source_a: assert property (
      (s_r.regs[ADDR_CHEN] != $past(s_r.regs[ADDR_CHEN])) |->
      (($past(wr_fire) && $past(s_r.ptr) == ADDR_CHEN) || ($past(~pin_s) != '0)))
      else $error("enable register changed without write or pin");

   // voltage code only moves by a host write or the fuse load
   code_source_a: assert property (
      (s_r.regs[ADDR_CH1] != $past(s_r.regs[ADDR_CH1])) |->
      (($past(wr_fire) && $past(s_r.ptr) == ADDR_CH1)
       || ($past(s_r.fuse_cnt) == FUSE_WAIT && !$past(s_r.fuse_done))))
      else $error("voltage code changed without write or fuse");
endmodule

// File: verification/pmic_i2c_host.sv
// i2c host model: open-drain sda, scl stands high between frames
module pmic_i2c_host (
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda_line
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int Q = 50;  // quarter of the 200 ns bit

   // idle bus: both lines released
   initial begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end

   // start or repeated start; waits past the device's ack release first
   task automatic start();
      sda_pull = 1'b0;
      #Q scl = 1'b1;
      #(2*Q) sda_pull = 1'b1;
      #(2*Q) scl = 1'b0;
      #Q;
   endtask

   // data moves only while scl low; sampled mid high phase
   task automatic put_bit(input logic b, output logic got);
      sda_pull = ~b;
      #Q scl = 1'b1;
      #Q got = sda_line;
      #Q scl = 1'b0;
      #Q;
   endtask

   // eight bits msb first, then the ack slot
   task automatic xfer(input logic [7:0] tx, input logic ack_in,
                       output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         put_bit(tx[i], rx[i]);
      end
      put_bit(ack_in, ack);
   endtask

   // stop: sda rises while scl high
   task automatic stop();
      sda_pull = 1'b1;
      #Q scl = 1'b1;
      #(2*Q) sda_pull = 1'b0;
      #(2*Q);
   endtask
endmodule

// File: verification/tb.sv
module tb;
   import pmic_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] DEV  = 7'h34;
   localparam logic [4:0] FUSE = 5'h13;
   localparam logic [3:0] PG   = 4'ha;
   logic                clk;
   logic                rstn;
   logic                scl;
   logic                sda_pull;
   wire logic           sda_line;
   logic                sda_o;
   logic                sda_oe;
   logic [NUM_CHAN-1:0] pins;
   logic [NUM_CHAN-1:0] chan_run;
   logic [CODE_W-1:0]   field;
   logic [10:0]         vout;
   logic [7:0]          cfg [11];
   int                  n_errors = 0;
   int                  tests_run = 0;
   int                  cycles = 0;

   // pulled-up wire, low when either party pulls
   assign sda_line = ~(sda_pull | sda_oe);

   pmic_i2c_host host (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));

   pmic_control_register_bank #(.DEV_ADDR(DEV)) dut (
      .clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
      .sda_oe(sda_oe), .chan_enable_pin(pins), .power_good_in(PG),
      .fuse_ch1_code(FUSE), .chan_run(chan_run), .ch1_voltage_field(field),
      .ch1_vout_mv(vout), .ch23_code_out(cfg[0]), .ch4_code_out(cfg[1]),
      .ramp_cfg_out(cfg[2]), .mode_cfg_out(cfg[3]), .latchoff_cfg_out(cfg[4]),
      .switching_cfg_out(cfg[5]), .threshold_cfg_out(cfg[6]),
      .retry_cfg_out(cfg[7]), .pg_select_out(cfg[8]),
      .event_mask_out(cfg[9]), .restore_cfg_out(cfg[10]));

   // 40 mhz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // hang guard, well above the few thousand cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // burst write from pointer a
   task automatic wrq(input logic [7:0] a, input logic [7:0] d[$]);
      logic [7:0] rx;
      logic       ak;
      // host edges fall 2 ns after clk edges, never on them
      @(posedge clk);
      #2;
      host.start();
      host.xfer({DEV, 1'b0}, 1'b1, rx, ak);
      chk("write address ack", 1'b0, ak);
      host.xfer(a, 1'b1, rx, ak);
      chk("pointer ack", 1'b0, ak);
      foreach (d[i]) begin
         host.xfer(d[i], 1'b1, rx, ak);
      end
      host.stop();
      repeat (4) @(posedge clk);
   endtask

   task automatic wr1(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q [$];
      q = {};
      q.push_back(d);
      wrq(a, q);
   endtask

   // burst read; host acks all but the last byte
   task automatic rd(input logic [7:0] a, input int n, output logic [7:0] q[$]);
      logic [7:0] rx;
      logic       ak;
      q = {};
      @(posedge clk);
      #2;
      host.start();
      host.xfer({DEV, 1'b0}, 1'b1, rx, ak);
      host.xfer(a, 1'b1, rx, ak);
      host.start();
      host.xfer({DEV, 1'b1}, 1'b1, rx, ak);
      chk("read address ack", 1'b0, ak);
      for (int i = 0; i < n; i++) begin
         host.xfer(8'hff, (i == n - 1), rx, ak);
         q.push_back(rx);
      end
      host.stop();
      repeat (4) @(posedge clk);
   endtask

   task automatic ck_reg(input string what, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q [$];
      rd(a, 1, q);
      chk(what, e, q[0]);
   endtask

   // pins are async; give the synchroniser and run logic time to settle
   task automatic set_pins(input logic [NUM_CHAN-1:0] v);
      @(posedge clk);
      #2 pins = v;
      repeat (8) @(posedge clk);
   endtask

   task automatic t_reset();
      ck_reg("enable reg", ADDR_CHEN, CHEN_RST);
      chk("sda drive", 1'b0, sda_o);
      ck_reg("ch1 code", ADDR_CH1, {3'h0, FUSE});
      chk("ch1 field", FUSE, field);
      chk("ch1 mv", 11'h514, vout);
      chk("run all", 5'h1f, chan_run);
   endtask

   // writes only land on channels whose pin is high
   task automatic t_gate();
      set_pins(5'h15);
      chk("run gated", 5'h15, chan_run);
      wr1(ADDR_CHEN, 8'he0);
      ck_reg("masked write", ADDR_CHEN, 8'hea);
      chk("run off", 5'h00, chan_run);
   endtask

   task automatic t_force();
      set_pins(5'h1f);
      chk("run mixed", 5'h0a, chan_run);
      set_pins(5'h1e);
      set_pins(5'h1f);
      ck_reg("forced bit", ADDR_CHEN, 8'heb);
      chk("run restart", 5'h0b, chan_run);
   endtask

   // end points and a few steps of the voltage code
   task automatic t_vcode();
      logic [4:0]  codes [5];
      logic [10:0] mv;
      codes = '{5'h00, 5'h01, 5'h02, 5'h07, 5'h1f};
      foreach (codes[i]) begin
         mv = (codes[i] == 5'h00) ? 11'h320 : 11'h339 + 11'h019 * codes[i];
         wr1(ADDR_CH1, {3'h0, codes[i]});
         chk("ch1 field", codes[i], field);
         chk("ch1 mv", mv, vout);
      end
   endtask

   // whole map, reserved and read-only places included, one past the end
   task automatic t_map();
      logic [7:0] q [$];
      logic [7:0] e;
      logic [7:0] ca [11];
      q = {};
      // address behind each configuration output, in port order
      ca = '{ADDR_CH23, ADDR_CH4, ADDR_RAMP, ADDR_MODE, ADDR_LATCH, ADDR_SWCFG,
             ADDR_THRESH, ADDR_RETRY, ADDR_PGSEL, ADDR_EVMASK, ADDR_LAST};
      for (int i = 3; i <= 17; i++) begin
         q.push_back(8'h40 + 8'(i));
      end
      wrq(ADDR_CH23, q);
      rd(ADDR_RSVD0, 19, q);
      foreach (q[i]) begin
         case (i)
            0, 16, 18: e = 8'h00;
            1:         e = 8'heb;
            2:         e = 8'h1f;
            13:        e = {4'h0, PG};
            default:   e = 8'h40 + 8'(i);
         endcase
         chk("map byte", e, q[i]);
      end
      foreach (cfg[i]) begin
         chk("cfg out", 8'h40 + ca[i], cfg[i]);
      end
   endtask

   // a foreign bus address gets no ack and changes nothing
   task automatic t_alien();
      logic [7:0] rx;
      logic       ak;
      @(posedge clk);
      #2;
      host.start();
      host.xfer({~DEV, 1'b0}, 1'b1, rx, ak);
      chk("foreign address ack", 1'b1, ak);
      host.xfer(ADDR_CH23, 1'b1, rx, ak);
      host.xfer(8'h99, 1'b1, rx, ak);
      host.stop();
      repeat (4) @(posedge clk);
      ck_reg("foreign write", ADDR_CH23, 8'h43);
   endtask

   task automatic t_rst2();
      @(posedge clk);
      #2 rstn = 1'b0;
      repeat (3) @(posedge clk);
      #2 rstn = 1'b1;
      repeat (40) @(posedge clk);
      ck_reg("cfg after reset", ADDR_CH23, 8'h00);
      ck_reg("enable after reset", ADDR_CHEN, CHEN_RST);
      chk("field after reset", FUSE, field);
   endtask

   // main sequence
   initial begin
      rstn = 1'b0;
      pins = 5'h1f;
      repeat (3) @(posedge clk);
      #2 rstn = 1'b1;
      repeat (40) @(posedge clk);
      t_reset();
      t_gate();
      t_force();
      t_vcode();
      t_map();
      t_alien();
      t_rst2();
      give_verdict();
   end
endmodule
